// ### bench/lpm_ctrl_asserts.sv
// Concurrent checks on the low power mode controller ports.
// Assumes one clock domain and the registered port timing of lpm_ctrl.
`timescale 1ns/1ps
module lpm_ctrl_asserts
  import lpm_pkg::*;
(
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_ce, // Enable
  input wire logic i_reset_pin_n, // Reset pin
  input wire logic i_sleep, // SLEEP pulse
  input wire logic i_irq, // Interrupt
  input wire logic i_irq_en, // Its enable
  input wire logic i_cc_mask, // CPU mask
  input wire logic i_wdt_osc_on, // Watchdog osc
  input wire logic [2:0] i_wake_wait_select, // Wait code
  input wire logic i_medium_speed_select, // Medium select
  input wire logic [2:0] o_mode, // Mode
  input wire logic o_main_osc_en, // Main osc
  input wire logic o_cpu_run, // CPU clock
  input wire logic o_cpu_reset, // CPU reset
  input wire logic o_periph_run, // Peripherals
  input wire logic o_rtc_run, // Timekeeping
  input wire logic o_adc_pwm_run, // ADC and PWM
  input wire logic o_use_subclock, // Subclock
  input wire logic [1:0] o_sub_div, // Sub divider
  input wire logic o_irq_start, // Irq pulse
  input wire logic o_reset_start, // Reset pulse
  input wire logic [7:0] o_pin_oe_n // Pin enables
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // Qualified wake request; pin and enable held so nothing else intervenes
  logic wake;
  assign wake = i_irq && i_irq_en && !i_cc_mask && i_ce && i_reset_pin_n;

  // Standby gating and wake timing
  a_standby_float: assert property (($past(o_mode) == LPM_STANDBY && o_mode == LPM_STANDBY) |-> o_pin_oe_n == 8'hff)
    else $error("pins driven in standby");
  a_standby_clocks_off: assert property (($past(o_mode) != LPM_STANDBY && o_mode == LPM_STANDBY
    && !$past(i_wdt_osc_on)) |-> (!o_main_osc_en && !o_cpu_run && !o_periph_run))
    else $error("clocks run in standby");
  a_standby_wake_time: assert property ((o_mode == LPM_STANDBY && !o_main_osc_en && wake
    && i_wake_wait_select == 3'h7) |=> (o_mode == LPM_STANDBY && o_main_osc_en)[*2] ##1
    (o_irq_start && o_mode == ($past(i_medium_speed_select, 3) ? LPM_ACTIVE_MS : LPM_ACTIVE_HS)))
    else $error("standby wake timing");
  // Masked or disabled interrupts keep the sleep
  a_masked_standby: assert property ((o_mode == LPM_STANDBY && !o_main_osc_en && !i_wdt_osc_on
    && i_reset_pin_n && (i_cc_mask || !i_irq_en)) |=> (o_mode == LPM_STANDBY && !o_main_osc_en))
    else $error("masked standby woke");
  a_masked_subsleep: assert property ((o_mode == LPM_SUBSLEEP && i_reset_pin_n && (i_cc_mask || !i_irq_en))
    |=> o_mode == LPM_SUBSLEEP)
    else $error("masked subsleep woke");
  // Per-mode block gating and subactive divider hold
  a_watch_gating: assert property (o_mode == LPM_WATCH |-> (!o_cpu_run && !o_periph_run && o_rtc_run))
    else $error("watch gating wrong");
  a_subsleep_gating: assert property (o_mode == LPM_SUBSLEEP |-> (!o_cpu_run && o_periph_run && !o_adc_pwm_run))
    else $error("subsleep gating wrong");
  a_subactive_clock: assert property (o_mode == LPM_SUBACTIVE
    |-> (o_use_subclock && !o_main_osc_en && o_cpu_run && !o_adc_pwm_run))
    else $error("subactive clocking wrong");
  a_subdiv_hold: assert property ((o_mode == LPM_SUBACTIVE && i_reset_pin_n && !i_sleep) |=> $stable(o_sub_div))
    else $error("sub divider moved without SLEEP");
  // Reset pin entry and exit
  a_pin_reset: assert property ((!i_reset_pin_n && i_ce) |=> (o_mode == LPM_RESET && o_cpu_reset))
    else $error("reset pin ignored");
  a_reset_exit: assert property ((o_mode == LPM_RESET && i_reset_pin_n && i_ce)
    |=> (o_mode == LPM_ACTIVE_HS && o_reset_start && !o_cpu_reset))
    else $error("reset exit wrong");

  c_standby_wake: cover property (o_mode == LPM_STANDBY ##1 o_irq_start);
  c_subactive: cover property (o_mode == LPM_SUBACTIVE);
  c_reset_exit: cover property (o_reset_start);
endmodule : lpm_ctrl_asserts

bind lpm_ctrl lpm_ctrl_asserts i_lpm_ctrl_asserts (.i_sys_clk, .i_rst, .i_ce, .i_reset_pin_n, .i_sleep, .i_irq,
  .i_irq_en, .i_cc_mask, .i_wdt_osc_on, .i_wake_wait_select, .i_medium_speed_select, .o_mode, .o_main_osc_en,
  .o_cpu_run, .o_cpu_reset, .o_periph_run, .o_rtc_run, .o_adc_pwm_run, .o_use_subclock, .o_sub_div,
  .o_irq_start, .o_reset_start, .o_pin_oe_n);

// ### bench/lpm_testbench.sv
// Self-checking bench for lpm_ctrl: sleep entry table, then wake, reset and divider cases.
// Assumes the checker is bound separately; inputs change on the falling clock edge.
`timescale 1ns/1ps
`include "lpm_consts.svh"
module testbench
  import lpm_pkg::*;
;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_reset_pin_n = 1'h1, i_sleep = 1'h0, i_irq = 1'h0;
  logic i_irq_en = 1'h1, i_cc_mask = 1'h0, i_wdt_osc_on = 1'h0, i_dt_irq_en = 1'h0, i_standby_select = 1'h0;
  logic i_low_speed_select = 1'h0, i_watch_select = 1'h0, i_medium_speed_select = 1'h0;
  logic i_direct_transfer_select = 1'h0;
  logic [2:0] i_wake_wait_select = 3'h7;
  logic [1:0] i_medium_divider = 2'h1, i_subactive_divider = 2'h0;
  logic [7:0] i_core_out = 8'ha5, i_core_oe_n = 8'h00;
  logic [2:0] o_mode;
  logic o_main_osc_en, o_cpu_run, o_cpu_reset, o_periph_run, o_rtc_run, o_adc_pwm_run, o_use_subclock;
  logic o_irq_start, o_reset_start;
  logic [1:0] o_sub_div, o_med_div;
  logic [7:0] o_pin_out, o_pin_oe_n;
  int miscompares = 0;
  int check_count = 0;
  typedef struct {logic sb; logic ls; logic wt; logic [2:0] md; logic [7:0] oe;} lpm_row_t;
  // Sleep entry from high speed: selects beside expected mode and pin enables
  lpm_row_t rows[3] = '{'{1'h0, 1'h0, 1'h0, LPM_SLEEP, 8'h00}, '{1'h1, 1'h0, 1'h0, LPM_STANDBY, 8'hff},
    '{1'h1, 1'h0, 1'h1, LPM_WATCH, 8'h00}};

  lpm_ctrl i_lpm_ctrl (.i_sys_clk, .i_rst, .i_ce, .i_reset_pin_n, .i_sleep, .i_irq, .i_irq_en, .i_cc_mask,
    .i_wdt_osc_on, .i_dt_irq_en, .i_standby_select, .i_low_speed_select, .i_watch_select, .i_wake_wait_select,
    .i_medium_divider, .i_medium_speed_select, .i_direct_transfer_select, .i_subactive_divider, .i_core_out,
    .i_core_oe_n, .o_mode, .o_main_osc_en, .o_cpu_run, .o_cpu_reset, .o_periph_run, .o_rtc_run, .o_adc_pwm_run,
    .o_use_subclock, .o_sub_div, .o_med_div, .o_irq_start, .o_reset_start, .o_pin_out, .o_pin_oe_n);

  // 10 MHz clock
  always #50 i_sys_clk = !i_sys_clk;

  task tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : tick

  task bad(input string m);
    miscompares++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task chk_mode(input logic [2:0] exp);
    check_count++;
    if (o_mode !== exp) bad($sformatf("mode %0h expected %0h", o_mode, exp));
  endtask : chk_mode

  task chk_v(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) bad($sformatf("value %0h expected %0h", got, exp));
  endtask : chk_v

  task do_reset;
    i_rst = 1'h1;
    tick(12);
    i_rst = 1'h0;
    tick(2);
  endtask : do_reset

  // SLEEP pulse of one cycle with the three select bits set first
  task sleep_with(input logic sb, input logic ls, input logic wt);
    i_standby_select = sb;
    i_low_speed_select = ls;
    i_watch_select = wt;
    i_sleep = 1'h1;
    tick(1);
    i_sleep = 1'h0;
    tick(2);
  endtask : sleep_with

  // Bounded wait for the interrupt start pulse; n counts cycles
  task wait_irq(output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (o_irq_start !== 1'h1 && n < 20000);
    i_irq = 1'h0;
  endtask : wait_irq

  task wrap_up;
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    int n;
    do_reset;
    chk_mode(LPM_ACTIVE_HS);
    chk_v(o_cpu_reset, 1'h0);
    foreach (rows[k])
    begin
      do_reset;
      sleep_with(rows[k].sb, rows[k].ls, rows[k].wt);
      chk_mode(rows[k].md);
      chk_v(o_pin_oe_n, rows[k].oe);
    end
    // Masked interrupt in standby, then wake to medium speed
    do_reset;
    i_cc_mask = 1'h1;
    sleep_with(1'h1, 1'h0, 1'h0);
    i_irq = 1'h1;
    tick(20);
    chk_mode(LPM_STANDBY);
    chk_v(o_main_osc_en, 1'h0);
    // Watchdog oscillator keeps the main oscillator alive in standby
    i_wdt_osc_on = 1'h1;
    tick(2);
    chk_v(o_main_osc_en, 1'h1);
    i_wdt_osc_on = 1'h0;
    i_medium_divider = 2'h2;
    tick(2);
    i_medium_speed_select = 1'h1;
    i_cc_mask = 1'h0;
    wait_irq(n);
    chk_v(n, `LPM_WAIT_7 + 2);
    chk_mode(LPM_ACTIVE_MS);
    chk_v(o_med_div, 2'h2);
    // Reset pin from medium speed, held past the code 7 settling time
    i_medium_speed_select = 1'h0;
    i_reset_pin_n = 1'h0;
    tick(2);
    chk_mode(LPM_RESET);
    chk_v(o_cpu_reset, 1'h1);
    i_reset_pin_n = 1'h1;
    tick(1);
    chk_mode(LPM_ACTIVE_HS);
    chk_v(o_reset_start, 1'h1);
    // Watch holds pins, wakes to high speed after settling
    sleep_with(1'h1, 1'h0, 1'h1);
    i_core_out = 8'h3c;
    tick(3);
    chk_v(o_pin_out, 8'ha5);
    i_wake_wait_select = 3'h6;
    i_irq = 1'h1;
    wait_irq(n);
    chk_v(n, `LPM_WAIT_6 + 2);
    chk_mode(LPM_ACTIVE_HS);
    // Watch to subactive; divider applies only at SLEEP
    sleep_with(1'h1, 1'h1, 1'h1);
    i_irq = 1'h1;
    tick(2);
    i_irq = 1'h0;
    chk_mode(LPM_SUBACTIVE);
    chk_v(o_use_subclock, 1'h1);
    i_subactive_divider = 2'h2;
    tick(3);
    chk_v(o_sub_div, 2'h0);
    sleep_with(1'h0, 1'h1, 1'h0);
    chk_mode(LPM_SUBSLEEP);
    chk_v(o_sub_div, 2'h2);
    i_irq_en = 1'h0;
    i_irq = 1'h1;
    tick(10);
    chk_mode(LPM_SUBSLEEP);
    i_irq_en = 1'h1;
    wait_irq(n);
    chk_v(n, 16'h0001);
    chk_mode(LPM_SUBACTIVE);
    // Direct transfers between speeds without halting
    do_reset;
    i_direct_transfer_select = 1'h1;
    i_dt_irq_en = 1'h1;
    i_medium_speed_select = 1'h1;
    sleep_with(1'h0, 1'h0, 1'h0);
    tick(20);
    chk_mode(LPM_ACTIVE_MS);
    i_medium_speed_select = 1'h0;
    sleep_with(1'h0, 1'h0, 1'h0);
    tick(20);
    chk_mode(LPM_ACTIVE_HS);
    wrap_up;
  end

  // Hang guard well beyond the longest expected run
  initial
  begin
    #(100 * 5000);
    miscompares++;
    wrap_up;
  end
endmodule : testbench

// ### common/lpm_consts.svh
// Constants for the low power mode controller: field widths, timing counts.
// Assumes inclusion by bare name from rtl files and the package.
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_WAIT_W 3
`define LPM_SUBDIV_W 2
`define LPM_MEDDIV_W 2
`define LPM_CLK_NS 100
// Oscillator settling per wake_wait_select code, in system clock states
`define LPM_WAIT_0 16'h2000
`define LPM_WAIT_1 16'h4000
`define LPM_WAIT_2 16'h0400
`define LPM_WAIT_3 16'h0800
`define LPM_WAIT_4 16'h1000
`define LPM_WAIT_5 16'h0040
`define LPM_WAIT_6 16'h0010
`define LPM_WAIT_7 16'h0001
`define LPM_CNT_W 16
// Subactive divider codes: watch clock /8, /4, /2
`define LPM_SUBDIV_RST 2'h0
`endif

// ### common/lpm_pkg.sv
// Types for the low power mode controller.
// Assumes lpm_consts.svh is on the include path.
`include "lpm_consts.svh"
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_ACTIVE_HS,
    LPM_ACTIVE_MS,
    LPM_SLEEP,
    LPM_STANDBY,
    LPM_WATCH,
    LPM_SUBSLEEP,
    LPM_SUBACTIVE,
    LPM_RESET
  } lpm_mode_t;
endpackage : lpm_pkg

// ### common/lpm_wait_if.sv
// Handshake between the mode sequencer and its settling-wait counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`include "lpm_consts.svh"
interface lpm_wait_if;
  logic start;
  logic [`LPM_WAIT_W-1:0] sel;
  logic done;
  modport seq (output start, output sel, input done);
  modport cnt (input start, input sel, output done);
endinterface : lpm_wait_if

// ### rtl/lpm_ctrl.sv
// Low power mode sequencer: mode state, clock and block enables, I/O gating.
// Assumes the CPU presents control bits and a one-cycle SLEEP pulse synchronously.
// Summary of operation
// R01: Standby stops main oscillator; CPU and peripherals stop unless watchdog oscillator runs. Code: main osc on with i_wdt_osc_on; CPU always off.
// R02: Standby floats all general-purpose I/O pins.
// R03: Standby wake restarts oscillator, waits settling time, then interrupt handling.
// R04: Standby exits to medium speed if medium select set, else high speed.
// R05: Interrupt mask or disabled interrupt keeps standby, watch, subsleep asleep.
// R06: Outside party holds reset pin low until oscillator is stable.
// R07: After oscillator settles and reset pin rises, reset handling starts.
// R08: Watch stops CPU and peripherals except RTC, aux timer, event counter.
// R09: Watch and subsleep keep I/O pins at previous levels.
// R10: Watch wake goes to high speed, medium speed or subactive by select bits.
// R11: Watch wake into active waits settling time before interrupt handling.
// R12: Subsleep halts CPU; peripherals run except ADC and PWM.
// R13: Subsleep wake starts interrupt handling and continues in subactive.
// R14: Subactive stops main oscillator; CPU and peripherals run from subclock.
// R15: Subactive left only by SLEEP; target from the five select bits.
// R16: Subactive clock is watch clock over 2, 4 or 8.
// R17: New subactive divider applies only after a SLEEP instruction.
// R18: Medium speed keeps everything running; peripherals use medium divider.
// R19: SLEEP in medium speed goes to standby, watch or sleep by selects.
// R20: Medium speed also moves directly to high speed or subactive.
// R21: Reset pin low in medium speed resets CPU and drops the mode.
// R22: SLEEP with direct transfer set switches active/subactive without halting; code halts in watch leaving subactive with standby and watch selects.
// R23: Mode register returns to high speed when reset handling begins.
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_ctrl
  import lpm_pkg::*;
(
  input wire logic i_sys_clk, // System clock, 10 MHz
  input wire logic i_rst, // Async reset, high
  input wire logic i_ce, // Clock enable
  input wire logic i_reset_pin_n, // External reset pin, low active
  input wire logic i_sleep, // SLEEP instruction pulse
  input wire logic i_irq, // Any interrupt request pending
  input wire logic i_irq_en, // That interrupt's enable bit
  input wire logic i_cc_mask, // Interrupt mask bit of condition_code_reg
  input wire logic i_wdt_osc_on, // Watchdog on-chip oscillator enabled
  input wire logic i_dt_irq_en, // Direct transition interrupt enabled
  input wire logic i_standby_select, // system_control_one
  input wire logic i_low_speed_select, // system_control_one
  input wire logic i_watch_select, // system_control_one
  input wire logic [2:0] i_wake_wait_select, // system_control_one
  input wire logic [1:0] i_medium_divider, // system_control_one, hi:lo
  input wire logic i_medium_speed_select, // system_control_two
  input wire logic i_direct_transfer_select, // system_control_two
  input wire logic [1:0] i_subactive_divider, // system_control_two, hi:lo
  input wire logic [7:0] i_core_out, // Port data from core
  input wire logic [7:0] i_core_oe_n, // Port enable from core, low drives
  output logic [2:0] o_mode, // Current mode code
  output logic o_main_osc_en, // Main oscillator runs
  output logic o_cpu_run, // CPU clock enabled
  output logic o_cpu_reset, // CPU held in reset
  output logic o_periph_run, // General peripherals clocked
  output logic o_rtc_run, // RTC, aux timer, event counter clocked
  output logic o_adc_pwm_run, // ADC and PWM clocked
  output logic o_use_subclock, // System runs from subclock
  output logic [1:0] o_sub_div, // Applied subactive divider
  output logic [1:0] o_med_div, // Applied medium divider
  output logic o_irq_start, // Start interrupt handling, pulse
  output logic o_reset_start, // Start reset handling, pulse
  output logic [7:0] o_pin_out, // Port pin data
  output logic [7:0] o_pin_oe_n // Port pin enable, low drives
);
  lpm_mode_t mode;
  lpm_mode_t next_mode;
  lpm_mode_t wake_to;
  lpm_mode_t next_wake_to;
  logic waiting;
  logic next_waiting;
  logic [1:0] sub_div;
  logic [1:0] next_sub_div;
  logic irq_start;
  logic next_irq_start;
  logic reset_start;
  logic next_reset_start;
  logic rst_wait;
  logic next_rst_wait;
  logic wake_ok;
  lpm_wait_if wif ();

  // Masked or disabled interrupts never wake the device
  assign wake_ok = i_irq && i_irq_en && !i_cc_mask; // R05
  assign wif.sel = i_wake_wait_select;

  // Mode sequencing
  always_comb
  begin
    next_mode = mode;
    next_wake_to = wake_to;
    next_waiting = waiting;
    next_sub_div = sub_div;
    next_irq_start = 1'b0;
    next_reset_start = 1'b0;
    next_rst_wait = rst_wait;
    wif.start = 1'b0;
    if (!i_reset_pin_n)
    begin
      // Oscillator restarts; pin holder must keep it low until stable
      next_mode = LPM_RESET; // R21 R06
      next_waiting = 1'b0;
      if (!rst_wait)
      begin
        wif.start = 1'b1;
        next_rst_wait = 1'b1;
      end
    end
    else if (mode == LPM_RESET)
    begin
      // Reset pin high: begin reset handling in high speed
      next_mode = LPM_ACTIVE_HS; // R07 R23
      next_reset_start = 1'b1;
      next_rst_wait = 1'b0;
    end
    else if (waiting)
    begin
      if (wif.done)
      begin
        next_mode = wake_to; // R03 R11
        next_waiting = 1'b0;
        next_irq_start = 1'b1;
      end
    end
    else
    begin
      unique case (mode)
        LPM_STANDBY:
          if (wake_ok)
          begin
            next_wake_to = i_medium_speed_select ? LPM_ACTIVE_MS : LPM_ACTIVE_HS; // R04
            next_waiting = 1'b1; // R03
            wif.start = 1'b1;
          end
        LPM_WATCH:
          if (wake_ok)
          begin
            if (i_low_speed_select)
            begin
              next_mode = LPM_SUBACTIVE; // R10
              next_irq_start = 1'b1;
            end
            else
            begin
              next_wake_to = i_medium_speed_select ? LPM_ACTIVE_MS : LPM_ACTIVE_HS; // R10
              next_waiting = 1'b1; // R11
              wif.start = 1'b1;
            end
          end
        LPM_SUBSLEEP, LPM_SLEEP:
          if (wake_ok)
          begin
            next_mode = (mode == LPM_SUBSLEEP) ? LPM_SUBACTIVE : LPM_ACTIVE_HS; // R13
            next_irq_start = 1'b1;
          end
        LPM_ACTIVE_HS, LPM_ACTIVE_MS, LPM_SUBACTIVE:
          if (i_sleep)
          begin
            // Divider latched at SLEEP so a write before it applies after
            next_sub_div = i_subactive_divider; // R17 R16
            if (i_direct_transfer_select && i_dt_irq_en && !i_cc_mask)
            begin
              // Direct transfer keeps the program running, except subactive to active via watch, halted while settling
              if (i_standby_select && i_watch_select && i_low_speed_select)
              begin
                next_mode = LPM_SUBACTIVE; // R22 R20
                next_irq_start = 1'b1;
              end
              else if (mode == LPM_SUBACTIVE && i_standby_select && i_watch_select)
              begin
                // Leaving subactive needs the oscillator to settle
                next_wake_to = i_medium_speed_select ? LPM_ACTIVE_MS : LPM_ACTIVE_HS; // R15 R22
                next_mode = LPM_WATCH;
                next_waiting = 1'b1;
                wif.start = 1'b1;
              end
              else if (!i_standby_select && !i_low_speed_select)
              begin
                next_mode = i_medium_speed_select ? LPM_ACTIVE_MS : LPM_ACTIVE_HS; // R20 R22
                next_irq_start = 1'b1;
              end
            end
            else if (mode == LPM_SUBACTIVE)
            begin
              if (!i_standby_select)
                next_mode = LPM_SUBSLEEP; // R15
              else if (i_watch_select)
                next_mode = LPM_WATCH; // R15
            end
            else if (!i_standby_select)
              next_mode = LPM_SLEEP; // R19
            else
              next_mode = i_watch_select ? LPM_WATCH : LPM_STANDBY; // R19
          end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode <= LPM_ACTIVE_HS;
      wake_to <= LPM_ACTIVE_HS;
      waiting <= 1'b0;
      sub_div <= `LPM_SUBDIV_RST;
      irq_start <= 1'b0;
      reset_start <= 1'b0;
      rst_wait <= 1'b0;
    end
    else if (i_ce)
    begin
      mode <= next_mode;
      wake_to <= next_wake_to;
      waiting <= next_waiting;
      sub_div <= next_sub_div;
      irq_start <= next_irq_start;
      reset_start <= next_reset_start;
      rst_wait <= next_rst_wait;
    end
  end

  // Per-mode clock and block enables, registered for clean outputs
  logic next_osc, next_cpu, next_per, next_rtc, next_adc, next_sub, next_cpurst;
  always_comb
  begin
    next_osc = 1'b1;
    next_cpu = 1'b0;
    next_per = 1'b0;
    next_rtc = 1'b1;
    next_adc = 1'b0;
    next_sub = 1'b0;
    next_cpurst = 1'b0;
    if (next_waiting)
    begin
      next_osc = 1'b1; // R03
    end
    else
    begin
      unique case (next_mode)
        LPM_ACTIVE_HS, LPM_ACTIVE_MS:
        begin
          next_cpu = 1'b1; // R18
          next_per = 1'b1;
          next_adc = 1'b1;
        end
        LPM_SLEEP:
        begin
          next_per = 1'b1;
          next_adc = 1'b1;
        end
        LPM_STANDBY:
        begin
          next_osc = i_wdt_osc_on; // R01
          next_rtc = i_wdt_osc_on;
          next_per = i_wdt_osc_on;
        end
        LPM_WATCH:
          next_osc = i_wdt_osc_on; // R08
        LPM_SUBSLEEP:
        begin
          next_osc = 1'b0;
          next_per = 1'b1; // R12
          next_sub = 1'b1;
        end
        LPM_SUBACTIVE:
        begin
          next_osc = 1'b0; // R14
          next_cpu = 1'b1;
          next_per = 1'b1;
          next_sub = 1'b1;
        end
        LPM_RESET:
          next_cpurst = 1'b1; // R21
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_main_osc_en <= 1'b1;
      o_cpu_run <= 1'b1;
      o_periph_run <= 1'b1;
      o_rtc_run <= 1'b1;
      o_adc_pwm_run <= 1'b1;
      o_use_subclock <= 1'b0;
      o_cpu_reset <= 1'b0;
      o_mode <= 3'h0;
      o_sub_div <= `LPM_SUBDIV_RST;
      o_med_div <= 2'h0;
      o_irq_start <= 1'b0;
      o_reset_start <= 1'b0;
    end
    else if (i_ce)
    begin
      o_main_osc_en <= next_osc;
      o_cpu_run <= next_cpu;
      o_periph_run <= next_per;
      o_rtc_run <= next_rtc;
      o_adc_pwm_run <= next_adc;
      o_use_subclock <= next_sub;
      o_cpu_reset <= next_cpurst;
      o_mode <= next_mode;
      o_sub_div <= next_sub_div; // R16
      o_med_div <= i_medium_divider; // R18
      o_irq_start <= next_irq_start;
      o_reset_start <= next_reset_start;
    end
  end

  lpm_wait_timer u_wait (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .w(wif.cnt)
  );

  // Standby floats pins; watch and subsleep freeze them
  lpm_port_hold #(.NPINS(8)) u_ports (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_float(mode == LPM_STANDBY), // R02
    .i_freeze(mode == LPM_WATCH || mode == LPM_SUBSLEEP), // R09
    .i_core_out(i_core_out),
    .i_core_oe_n(i_core_oe_n),
    .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n)
  );
endmodule : lpm_ctrl

// ### rtl/lpm_port_hold.sv
// Per-pin I/O gating: float in standby, freeze level in watch and subsleep.
// Assumes mode controls arrive registered from the sequencer.
`timescale 1ns/1ps
module lpm_port_hold #(
  parameter int NPINS = 8
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_ce, // Clock enable
  input wire logic i_float, // Standby: release pins
  input wire logic i_freeze, // Watch/subsleep: keep level
  input wire logic [NPINS-1:0] i_core_out, // Core pin data
  input wire logic [NPINS-1:0] i_core_oe_n, // Core enable, low drives
  output logic [NPINS-1:0] o_pin_out, // Pin data
  output logic [NPINS-1:0] o_pin_oe_n // Pin enable, low drives
);
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      logic held_out;
      logic held_oe_n;
      logic next_out;
      logic next_oe_n;
      // Frozen pins keep the last registered value
      always_comb
      begin
        next_out = held_out;
        next_oe_n = held_oe_n;
        if (i_float)
        begin
          next_oe_n = 1'b1; // R02
        end
        else if (!i_freeze)
        begin
          next_out = i_core_out[g];
          next_oe_n = i_core_oe_n[g];
        end
      end
      always_ff @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          held_out <= 1'b0;
          held_oe_n <= 1'b1;
        end
        else if (i_ce)
        begin
          held_out <= next_out;
          held_oe_n <= next_oe_n;
        end
      end
      assign o_pin_out[g] = held_out;
      assign o_pin_oe_n[g] = held_oe_n;
    end
  endgenerate
endmodule : lpm_port_hold

// ### rtl/lpm_wait_timer.sv
// Oscillator settling counter started by the sequencer.
// Assumes start pulses only while no wait is running.
`timescale 1ns/1ps
`include "lpm_consts.svh"
module lpm_wait_timer (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_ce, // Clock enable
  lpm_wait_if.cnt w // Wait handshake
);
  logic [`LPM_CNT_W-1:0] cnt;
  logic [`LPM_CNT_W-1:0] next_cnt;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic [`LPM_CNT_W-1:0] load;

  // Wait length per select code
  always_comb
  begin
    unique case (w.sel)
      3'h0: load = `LPM_WAIT_0;
      3'h1: load = `LPM_WAIT_1;
      3'h2: load = `LPM_WAIT_2;
      3'h3: load = `LPM_WAIT_3;
      3'h4: load = `LPM_WAIT_4;
      3'h5: load = `LPM_WAIT_5;
      3'h6: load = `LPM_WAIT_6;
      3'h7: load = `LPM_WAIT_7;
    endcase
  end

  // Countdown; done is a one-cycle pulse at expiry
  always_comb
  begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (w.start)
    begin
      next_cnt = load;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      if (cnt <= 16'h0001)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_cnt = cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign w.done = done;
endmodule : lpm_wait_timer
